// file: src/pcmf_consts.vh
// Register map, field positions and reset values of the PCM framer block
`ifndef PCMF_CONSTS_VH
`define PCMF_CONSTS_VH
// Register byte addresses
`define PCMF_A_CTRL 8'h00
`define PCMF_A_FRAME 8'h04
`define PCMF_A_SYNCLEN 8'h08
`define PCMF_A_PATLO 8'h0c
`define PCMF_A_PATHI 8'h10
`define PCMF_A_CORR 8'h14
`define PCMF_A_GDIV 8'h18
`define PCMF_A_STAT 8'h1c
`define PCMF_A_ISTAT 8'h20
`define PCMF_A_ICLR 8'h24
`define PCMF_A_IEN 8'h28
// Control bit positions
`define PCMF_C_GEN_EN 0
`define PCMF_C_GEN_PAT 1
`define PCMF_C_GEN_SUBFRAME_COUNTER 2
`define PCMF_C_RX_EN 3
`define PCMF_C_RX_SUBFRAME_COUNTER 4
`define PCMF_C_RX_STRIP 5
`define PCMF_C_LOCK_SEL 6
`define PCMF_C_SDET_SEL 7
// Field least significant bits
`define PCMF_F_LEN_LSB 0
`define PCMF_F_MAJ_LSB 16
`define PCMF_F_WL_LSB 24
`define PCMF_K_THR_LSB 0
`define PCMF_K_WIN_LSB 8
`define PCMF_K_LOCK_LSB 16
`define PCMF_K_LOSS_LSB 24
// Interrupt bit positions
`define PCMF_I_LOCK 0
`define PCMF_I_LOSS 1
`define PCMF_I_SFERR 2
`define PCMF_I_MAJOR 3
// Writable bit masks
`define PCMF_M_CTRL 32'h000000ff
`define PCMF_M_FRAME 32'h0fff3fff
`define PCMF_M_SYNCLEN 32'h0000003f
`define PCMF_M_PATHI 32'h00000001
`define PCMF_M_CORR 32'h0f0f3f3f
`define PCMF_M_GDIV 32'h0000ffff
`define PCMF_M_IRQ 32'h0000000f
// Reset values
`define PCMF_R_CTRL 32'h00000000
`define PCMF_R_FRAME 32'h0f0301ff
`define PCMF_R_SYNCLEN 32'h00000018
`define PCMF_R_PATLO 32'h00fe6b28
`define PCMF_R_PATHI 32'h00000000
`define PCMF_R_CORR 32'h02020116
`define PCMF_R_GDIV 32'h00000003
// Sync word length bounds and pattern generator seed
`define PCMF_SYNC_MIN 6'h10
`define PCMF_SYNC_MAX 6'h21
`define PCMF_PRBS_SEED 15'h7fff
`endif

// file: src/pcmf_corr.v
// Sync word correlator: counts matching bits over the programmed length
`timescale 1ns/1ps
module pcmf_corr (
	input wire [32:0] win_i,
	input wire [32:0] pat_i,
	input wire [5:0] len_i,
	output reg [5:0] cnt_o
);
	wire [32:0] match;
	integer i;

	// Per-bit agreement, masked to the active sync length
	genvar g;
	generate
		for (g = 0; g < 33; g = g + 1) begin : g_bit
			assign match[g] = (g < len_i) & ~(win_i[g] ^ pat_i[g]);
		end
	endgenerate

	// Population count of agreeing bits
	always @* begin
		cnt_o = 6'h00;
		for (i = 0; i < 33; i = i + 1) begin
			cnt_o = cnt_o + {5'h00, match[i]};
		end
	end
endmodule

// file: src/pcmf_top.v
// PCM minor frame generator and recogniser with Wishbone registers
//
// Functional notes
// - Major frame holds 1 to 256 minor frames of one fixed length.
// - Minor frame length up to 16384 bits including sync word.
// - Sync word length 16 to 33 bits with programmable pattern.
// - Generator inserts subframe counter after sync, counting 1..Z then 1.
// - Payload bits come unaligned from external input or pattern source.
// - Subframe counter check is optional and reads word one only.
// - Window sets bits early or late a sync may still be accepted.
// - Threshold sets the sync bit match count that must be exceeded to detect.
// - Search slides every bit, detecting when matches exceed threshold.
// - Check declares lock after lock-count consecutive valid syncs.
// - Lock holds until loss-count consecutive invalid syncs occur.
// - While locked, read the counter from the word after sync.
// - Counter valid if previous plus one, or 1 after Z.
// - Counter validation only while frame lock is held.
// - Optionally strip sync word and counter word from output stream.
// - Lock and counter-valid status selectable on two discrete outputs.
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "pcmf_consts.vh"
module pcmf_top (
	input wire CLOCK_I,
	input wire RST_N_I,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output reg [31:0] WB_DAT_O,
	output reg WB_ACK_O,
	input wire GEN_EXT_BIT_I,
	output wire GEN_EXT_REQ_O,
	output reg GEN_BIT_O,
	output reg GEN_BIT_EN_O,
	input wire RX_BIT_I,
	input wire RX_BIT_EN_I,
	output reg RX_DATA_O,
	output reg RX_DATA_EN_O,
	output reg LOCK_INDICATOR_OUT_O,
	output reg SYNC_DETECT_O,
	output reg IRQ_O
);
	localparam ST_SEARCH = 2'b00;
	localparam ST_CHECK = 2'b01;
	localparam ST_LOCK = 2'b10;

	reg [31:0] ctrl_r, frame_r, synclen_r, patlo_r, pathi_r, corr_r, gdiv_r;
	reg [31:0] istat_r, ien_r;
	reg [31:0] rd_data;
	reg [15:0] g_div_r;
	reg [13:0] g_pos_r;
	reg [8:0] g_subframe_counter_r;
	reg [14:0] g_prbs_r;
	reg [33:0] sh_r;
	reg [1:0] st_r, st_nxt;
	reg [14:0] bcnt_r, bcnt_nxt;
	reg [3:0] hit_r, hit_nxt, miss_r, miss_nxt;
	reg ev_lock, ev_loss;
	reg [15:0] sf_sh_r, sf_prev_r;
	reg sf_seen_r, sf_ok_r;
	reg g_bit;

	// Write data merge by byte lanes
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		integer k;
		begin
			wmerge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (sel[k]) begin
					wmerge[k*8 +: 8] = nw[k*8 +: 8];
				end
			end
		end
	endfunction

	// Configuration fields
	wire gen_en = ctrl_r[`PCMF_C_GEN_EN];
	wire gen_pat = ctrl_r[`PCMF_C_GEN_PAT];
	wire gen_subframe_counter = ctrl_r[`PCMF_C_GEN_SUBFRAME_COUNTER];
	wire rx_en = ctrl_r[`PCMF_C_RX_EN];
	wire rx_subframe_counter = ctrl_r[`PCMF_C_RX_SUBFRAME_COUNTER];
	wire rx_strip = ctrl_r[`PCMF_C_RX_STRIP];
	wire [13:0] flen_m1 = frame_r[`PCMF_F_LEN_LSB +: 14];
	wire [7:0] major_m1 = frame_r[`PCMF_F_MAJ_LSB +: 8];
	wire [8:0] major_z = {1'b0, major_m1} + 9'h001;
	wire [4:0] wl = {1'b0, frame_r[`PCMF_F_WL_LSB +: 4]} + 5'h01;
	wire [5:0] thr = corr_r[`PCMF_K_THR_LSB +: 6];
	wire [5:0] win = corr_r[`PCMF_K_WIN_LSB +: 6];
	wire [3:0] lock_thr = corr_r[`PCMF_K_LOCK_LSB +: 4];
	wire [3:0] loss_thr = corr_r[`PCMF_K_LOSS_LSB +: 4];
	wire [5:0] slen_raw = synclen_r[5:0];
	// Sync length held inside its legal span
	wire [5:0] slen = (slen_raw < `PCMF_SYNC_MIN) ? `PCMF_SYNC_MIN :
		(slen_raw > `PCMF_SYNC_MAX) ? `PCMF_SYNC_MAX : slen_raw;
	wire [32:0] pattern = {pathi_r[0], patlo_r};

	// Wishbone classic slave, one wait state
	wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	wire wb_wr = wb_req & WB_WE_I;
	wire [31:0] iclr = (wb_wr && WB_ADR_I == `PCMF_A_ICLR) ?
		wmerge(32'h00000000, WB_DAT_I, WB_SEL_I) : 32'h00000000;

	// Read multiplexer, unmapped addresses read zero
	always @* begin
		case (WB_ADR_I)
			`PCMF_A_CTRL: rd_data = ctrl_r;
			`PCMF_A_FRAME: rd_data = frame_r;
			`PCMF_A_SYNCLEN: rd_data = synclen_r;
			`PCMF_A_PATLO: rd_data = patlo_r;
			`PCMF_A_PATHI: rd_data = pathi_r;
			`PCMF_A_CORR: rd_data = corr_r;
			`PCMF_A_GDIV: rd_data = gdiv_r;
			`PCMF_A_STAT: rd_data = {7'h00, sf_prev_r[8:0], 12'h000, sf_ok_r,
				st_r == ST_LOCK, st_r};
			`PCMF_A_ISTAT: rd_data = istat_r;
			`PCMF_A_IEN: rd_data = ien_r;
			default: rd_data = 32'h00000000;
		endcase
	end

	// Bus answer and register writes
	always @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
			ctrl_r <= `PCMF_R_CTRL;
			frame_r <= `PCMF_R_FRAME;
			synclen_r <= `PCMF_R_SYNCLEN;
			patlo_r <= `PCMF_R_PATLO;
			pathi_r <= `PCMF_R_PATHI;
			corr_r <= `PCMF_R_CORR;
			gdiv_r <= `PCMF_R_GDIV;
			ien_r <= 32'h00000000;
		end else begin
			WB_ACK_O <= wb_req;
			if (wb_req && !WB_WE_I) begin
				WB_DAT_O <= rd_data;
			end
			if (wb_wr) begin
				case (WB_ADR_I)
					`PCMF_A_CTRL: ctrl_r <= wmerge(ctrl_r, WB_DAT_I,
						WB_SEL_I) & `PCMF_M_CTRL;
					`PCMF_A_FRAME: frame_r <= wmerge(frame_r, WB_DAT_I,
						WB_SEL_I) & `PCMF_M_FRAME;
					`PCMF_A_SYNCLEN: synclen_r <= wmerge(synclen_r, WB_DAT_I,
						WB_SEL_I) & `PCMF_M_SYNCLEN;
					`PCMF_A_PATLO: patlo_r <= wmerge(patlo_r, WB_DAT_I,
						WB_SEL_I);
					`PCMF_A_PATHI: pathi_r <= wmerge(pathi_r, WB_DAT_I,
						WB_SEL_I) & `PCMF_M_PATHI;
					`PCMF_A_CORR: corr_r <= wmerge(corr_r, WB_DAT_I,
						WB_SEL_I) & `PCMF_M_CORR;
					`PCMF_A_GDIV: gdiv_r <= wmerge(gdiv_r, WB_DAT_I,
						WB_SEL_I) & `PCMF_M_GDIV;
					`PCMF_A_IEN: ien_r <= wmerge(ien_r, WB_DAT_I,
						WB_SEL_I) & `PCMF_M_IRQ;
					default: ctrl_r <= ctrl_r;
				endcase
			end
		end
	end

	// Generator bit source selection
	wire g_tick = gen_en & (g_div_r == gdiv_r[15:0]);
	wire [13:0] g_slen = {8'h00, slen};
	wire g_in_sync = g_pos_r < g_slen;
	wire g_in_subframe_counter = gen_subframe_counter & ~g_in_sync &
		(g_pos_r < g_slen + {9'h000, wl});
	wire [13:0] g_off = g_pos_r - g_slen;
	wire [5:0] g_sidx = slen - 6'h01 - g_pos_r[5:0];
	wire [3:0] g_fidx = wl[3:0] - 4'h1 - g_off[3:0];
	wire [15:0] g_sword = {7'h00, g_subframe_counter_r};
	wire g_payload = ~g_in_sync & ~g_in_subframe_counter;
	wire g_prbs_bit = g_prbs_r[14] ^ g_prbs_r[13];
	wire g_end = g_pos_r == flen_m1;
	assign GEN_EXT_REQ_O = g_tick & g_payload & ~gen_pat;

	always @* begin
		if (g_in_sync) begin
			g_bit = pattern[g_sidx];
		end else if (g_in_subframe_counter) begin
			g_bit = g_sword[g_fidx];
		end else begin
			g_bit = gen_pat ? g_prbs_bit : GEN_EXT_BIT_I;
		end
	end

	// Generator bit timing, position and subframe counter
	always @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			g_div_r <= 16'h0000;
			g_pos_r <= 14'h0000;
			g_subframe_counter_r <= 9'h001;
			g_prbs_r <= `PCMF_PRBS_SEED;
			GEN_BIT_O <= 1'b0;
			GEN_BIT_EN_O <= 1'b0;
		end else if (!gen_en) begin
			g_div_r <= 16'h0000;
			g_pos_r <= 14'h0000;
			g_subframe_counter_r <= 9'h001;
			GEN_BIT_EN_O <= 1'b0;
		end else begin
			g_div_r <= g_tick ? 16'h0000 : g_div_r + 16'h0001;
			GEN_BIT_EN_O <= g_tick;
			if (g_tick) begin
				GEN_BIT_O <= g_bit;
				g_pos_r <= g_end ? 14'h0000 : g_pos_r + 14'h0001;
				if (g_end) begin
					g_subframe_counter_r <= (g_subframe_counter_r >= major_z) ? 9'h001 :
						g_subframe_counter_r + 9'h001;
				end
				if (g_payload && gen_pat) begin
					g_prbs_r <= {g_prbs_r[13:0], g_prbs_bit};
				end
			end
		end
	end

	// Receive window including the arriving bit
	wire [33:0] sh_nxt = {sh_r[32:0], RX_BIT_I};
	wire [5:0] match_cnt;
	wire rx_tick = rx_en & RX_BIT_EN_I;

	pcmf_corr u_corr (
		.win_i(sh_nxt[32:0]),
		.pat_i(pattern),
		.len_i(slen),
		.cnt_o(match_cnt)
	);

	wire det = match_cnt > thr;
	wire [14:0] exp_pos = {1'b0, flen_m1};
	wire [14:0] win_ext = {9'h000, win};
	wire [14:0] lo = (win_ext > exp_pos) ? 15'h0000 : exp_pos - win_ext;
	wire [14:0] hi = exp_pos + win_ext;
	wire in_win = (bcnt_r >= lo) && (bcnt_r <= hi);
	wire at_late = bcnt_r == hi;

	// Frame synchroniser next state
	always @* begin
		st_nxt = st_r;
		bcnt_nxt = bcnt_r + 15'h0001;
		hit_nxt = hit_r;
		miss_nxt = miss_r;
		ev_lock = 1'b0;
		ev_loss = 1'b0;
		case (st_r)
			ST_SEARCH: begin
				if (det) begin
					st_nxt = ST_CHECK;
					bcnt_nxt = 15'h0000;
					hit_nxt = 4'h0;
					miss_nxt = 4'h0;
				end
			end
			ST_CHECK: begin
				if (in_win && det) begin
					bcnt_nxt = 15'h0000;
					if ({1'b0, hit_r} + 5'h01 >= {1'b0, lock_thr}) begin
						st_nxt = ST_LOCK;
						hit_nxt = 4'h0;
						ev_lock = 1'b1;
					end else begin
						hit_nxt = hit_r + 4'h1;
					end
				end else if (at_late) begin
					st_nxt = ST_SEARCH;
					hit_nxt = 4'h0;
					miss_nxt = 4'h0;
				end
			end
			ST_LOCK: begin
				if (in_win && det) begin
					bcnt_nxt = 15'h0000;
					miss_nxt = 4'h0;
				end else if (at_late) begin
					bcnt_nxt = win_ext;
					if ({1'b0, miss_r} + 5'h01 >= {1'b0, loss_thr}) begin
						st_nxt = ST_SEARCH;
						miss_nxt = 4'h0;
						hit_nxt = 4'h0;
						ev_loss = 1'b1;
					end else begin
						miss_nxt = miss_r + 4'h1;
					end
				end
			end
			default: st_nxt = ST_SEARCH;
		endcase
	end

	// Subframe counter word as received
	wire [15:0] sf_word = {sf_sh_r[14:0], RX_BIT_I};
	wire [15:0] sf_mask = ~(16'hffff << wl);
	wire [15:0] sf_val = sf_word & sf_mask;
	wire sf_at = (st_r == ST_LOCK) && (st_nxt == ST_LOCK) && rx_subframe_counter &&
		(bcnt_nxt == {10'h000, wl});
	wire sf_good = (sf_val == sf_prev_r + 16'h0001) ||
		(sf_val == 16'h0001 && sf_prev_r == {7'h00, major_z});
	wire ev_sferr = rx_tick & sf_at & sf_seen_r & ~sf_good;
	wire [14:0] strip_end = {9'h000, slen} +
		(rx_subframe_counter ? {10'h000, wl} : 15'h0000);
	wire strip_now = rx_strip && st_r == ST_LOCK && bcnt_nxt != 15'h0000 &&
		bcnt_nxt <= strip_end;

	// Receive path, synchroniser state and counter check
	always @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sh_r <= 34'h000000000;
			st_r <= ST_SEARCH;
			bcnt_r <= 15'h0000;
			hit_r <= 4'h0;
			miss_r <= 4'h0;
			sf_sh_r <= 16'h0000;
			sf_prev_r <= 16'h0000;
			sf_seen_r <= 1'b0;
			sf_ok_r <= 1'b0;
			RX_DATA_O <= 1'b0;
			RX_DATA_EN_O <= 1'b0;
		end else if (!rx_en) begin
			st_r <= ST_SEARCH;
			hit_r <= 4'h0;
			miss_r <= 4'h0;
			sf_seen_r <= 1'b0;
			sf_ok_r <= 1'b0;
			RX_DATA_EN_O <= 1'b0;
		end else begin
			RX_DATA_EN_O <= 1'b0;
			if (RX_BIT_EN_I) begin
				sh_r <= sh_nxt;
				st_r <= st_nxt;
				bcnt_r <= bcnt_nxt;
				hit_r <= hit_nxt;
				miss_r <= miss_nxt;
				sf_sh_r <= sf_word;
				RX_DATA_O <= sh_nxt[slen];
				RX_DATA_EN_O <= ~strip_now;
				if (st_nxt != ST_LOCK) begin
					sf_seen_r <= 1'b0;
					sf_ok_r <= 1'b0;
				end else if (sf_at) begin
					sf_prev_r <= sf_val;
					sf_seen_r <= 1'b1;
					if (sf_seen_r) begin
						sf_ok_r <= sf_good;
					end
				end
			end
		end
	end

	// Discrete status outputs with selectable source
	always @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			LOCK_INDICATOR_OUT_O <= 1'b0;
			SYNC_DETECT_O <= 1'b0;
		end else begin
			LOCK_INDICATOR_OUT_O <= ctrl_r[`PCMF_C_LOCK_SEL] ? sf_ok_r :
				(st_r == ST_LOCK);
			SYNC_DETECT_O <= ctrl_r[`PCMF_C_SDET_SEL] ? sf_ok_r :
				(st_r == ST_LOCK);
		end
	end

	// Sticky event flags, set wins over clear
	wire [31:0] ev_vec = {28'h0000000, g_tick & g_end & (g_subframe_counter_r >= major_z),
		ev_sferr, rx_tick & ev_loss, rx_tick & ev_lock};

	always @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			istat_r <= 32'h00000000;
			IRQ_O <= 1'b0;
		end else begin
			istat_r <= ((istat_r & ~iclr) | ev_vec) & `PCMF_M_IRQ;
			IRQ_O <= |(istat_r & ien_r);
		end
	end
endmodule

// file: sim/pcmf_bitsync.sv
// Bit synchroniser model feeding the recogniser from the serial stream
`timescale 1ns/1ps
module pcmf_bitsync (
	input logic clk_i,
	input logic rst_n_i,
	input logic bit_i,
	input logic en_i,
	input logic flip_i,
	output logic bit_o,
	output logic en_o
);
	// One strobe per bit, optional inversion; line toggles between strobes
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_o <= 1'b0;
			en_o <= 1'b0;
		end else begin
			en_o <= en_i;
			bit_o <= en_i ? bit_i ^ flip_i : ~bit_o;
		end
	end
endmodule

// file: sim/pcmf_monitor.sv
// Timing checks on bus, stream and status ports of the PCM framer
`timescale 1ns/1ps
module pcmf_monitor (
	input logic CLOCK_I,
	input logic RST_N_I,
	input logic WB_CYC_I,
	input logic WB_STB_I,
	input logic WB_WE_I,
	input logic [7:0] WB_ADR_I,
	input logic [31:0] WB_DAT_O,
	input logic WB_ACK_O,
	input logic GEN_EXT_BIT_I,
	input logic GEN_EXT_REQ_O,
	input logic GEN_BIT_O,
	input logic GEN_BIT_EN_O,
	input logic RX_BIT_EN_I,
	input logic RX_DATA_EN_O,
	input logic LOCK_INDICATOR_OUT_O,
	input logic SYNC_DETECT_O,
	input logic IRQ_O
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);
	// Bus request and its single answer
	sequence s_req;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence s_ans;
		WB_ACK_O ##1 !WB_ACK_O;
	endsequence
	a_bus_answer: assert property (s_req |=> s_ans)
		else $error("bus request not answered by one ack");
	a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
		else $error("ack without request");
	a_unmapped_zero: assert property (WB_ACK_O && !$past(WB_WE_I) &&
		$past(WB_ADR_I) >= 8'h2c |-> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	a_gen_payload: assert property (GEN_EXT_REQ_O |=>
		GEN_BIT_EN_O && GEN_BIT_O == $past(GEN_EXT_BIT_I))
		else $error("payload bit not forwarded");
	a_rx_strobe: assert property (RX_DATA_EN_O |-> $past(RX_BIT_EN_I))
		else $error("output strobe without input bit");
	a_lock_cause: assert property ($changed(LOCK_INDICATOR_OUT_O) |->
		$past(RX_BIT_EN_I, 2) || $past(WB_ACK_O) || $past(WB_ACK_O, 2))
		else $error("lock output moved without cause");
	a_sdet_cause: assert property ($changed(SYNC_DETECT_O) |->
		$past(RX_BIT_EN_I, 2) || $past(WB_ACK_O) || $past(WB_ACK_O, 2))
		else $error("sync detect moved without cause");
	a_irq_clear: assert property ($fell(IRQ_O) |->
		$past(WB_ACK_O) || $past(WB_ACK_O, 2))
		else $error("interrupt fell without a write");
endmodule
bind pcmf_top pcmf_monitor i_pcmf_monitor (.CLOCK_I(CLOCK_I),
	.RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .GEN_EXT_BIT_I(GEN_EXT_BIT_I),
	.GEN_EXT_REQ_O(GEN_EXT_REQ_O), .GEN_BIT_O(GEN_BIT_O),
	.GEN_BIT_EN_O(GEN_BIT_EN_O), .RX_BIT_EN_I(RX_BIT_EN_I),
	.RX_DATA_EN_O(RX_DATA_EN_O), .LOCK_INDICATOR_OUT_O(LOCK_INDICATOR_OUT_O),
	.SYNC_DETECT_O(SYNC_DETECT_O), .IRQ_O(IRQ_O));

// file: sim/tb.sv
// Self-checking bench: generator looped into recogniser via the model
`timescale 1ns/1ps
`include "pcmf_consts.vh"
module tb;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ext = 0, flip = 0;
	logic gchk = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rd, dat_o;
	logic ack, req, gbit, gen, rbit, ren, rdat, rden, lock, sdet, irq;
	integer errors = 0, samples_checked = 0, seed = 50896;
	integer gpos = 0, fidx = 0, i, n, rnd, slen_b = 24;
	logic pq[$];
	logic gpat = 0, pbit, ge;
	logic [14:0] pr = `PCMF_PRBS_SEED;
	logic [32:0] ptn_b = {1'b0, `PCMF_R_PATLO};
	logic [24:0] hist = 25'h0;
	logic [31:0] rv [8] = '{`PCMF_R_CTRL, `PCMF_R_FRAME, `PCMF_R_SYNCLEN,
		`PCMF_R_PATLO, `PCMF_R_PATHI, `PCMF_R_CORR, `PCMF_R_GDIV, 32'h0};
	always #5 clk = ~clk;
	pcmf_top i_pcmf_top (.CLOCK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
		.WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.GEN_EXT_BIT_I(ext), .GEN_EXT_REQ_O(req), .GEN_BIT_O(gbit),
		.GEN_BIT_EN_O(gen), .RX_BIT_I(rbit), .RX_BIT_EN_I(ren),
		.RX_DATA_O(rdat), .RX_DATA_EN_O(rden), .LOCK_INDICATOR_OUT_O(lock),
		.SYNC_DETECT_O(sdet), .IRQ_O(irq));
	pcmf_bitsync i_pcmf_bitsync (.clk_i(clk), .rst_n_i(rst_n), .bit_i(gbit),
		.en_i(gen), .flip_i(flip), .bit_o(rbit), .en_o(ren));
	// Random external payload
	always @(posedge clk) begin
		rnd = $random(seed);
		ext <= rnd[0];
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Classic single cycle, held until ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		// Request stands until ack is sampled high at a rising edge
		do @(posedge clk); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Waits for the lock level; the watchdog bounds it
	task wt_lock(input logic v);
		while (lock !== v) @(negedge clk);
	endtask
	// Expected generated bit: sync, counter word, payload
	function logic gexp(input integer p, input integer f, input logic pl);
		logic [7:0] c;
		c = 8'(f % 3 + 1);
		if (p < slen_b) return ptn_b[slen_b - 1 - p];
		if (p < slen_b + 8) return c[slen_b + 7 - p];
		return pl;
	endfunction
	// Generator stream monitor
	always @(negedge clk) begin
		if (req === 1'b1) pq.push_back(ext);
		if (gchk && gen === 1'b1) begin
			pbit = 1'b0;
			// Payload from the queue or the bench's own PRBS15 copy
			if (gpos >= slen_b + 8 && gpat) begin
				pbit = pr[14] ^ pr[13];
				pr = {pr[13:0], pbit};
			end else if (gpos >= slen_b + 8) begin
				pbit = pq.pop_front();
			end
			ge = gexp(gpos, fidx, pbit);
			chk("gen_bit", gbit, ge);
			gpos = (gpos + 1) % 64;
			if (gpos == 0) fidx++;
		end
	end
	task final_report;
		if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		final_report;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 8; i++) begin
			wb(1'b0, {i[5:0], 2'b00}, 32'h0);
			chk("reset_value", rd, rv[i]);
		end
		wb(1'b1, 8'h30, 32'hffffffff);
		wb(1'b0, 8'h30, 32'h0);
		chk("unmapped", rd, 32'h0);
		// 64-bit minors, three per major, 8-bit words
		wb(1'b1, `PCMF_A_FRAME, 32'h0702003f);
		wb(1'b1, `PCMF_A_CORR, 32'h02020114);
		wb(1'b1, `PCMF_A_IEN, 32'h3);
		gchk = 1;
		wb(1'b1, `PCMF_A_CTRL, 32'h1d);
		wt_lock(1'b1);
		wb(1'b0, `PCMF_A_STAT, 32'h0);
		chk("state_lock", rd[2:0], 3'b110);
		chk("sync_detect", sdet, 1'b1);
		chk("irq_lock", irq, 1'b1);
		repeat (800) @(posedge clk);
		wb(1'b0, `PCMF_A_STAT, 32'h0);
		chk("counter_valid", rd[3], 1'b1);
		wb(1'b1, `PCMF_A_ICLR, 32'hf);
		repeat (3) @(negedge clk);
		chk("irq_clear", irq, 1'b0);
		wb(1'b1, `PCMF_A_CTRL, 32'h9d);
		repeat (3) @(negedge clk);
		chk("sdet_valid", sdet, 1'b1);
		// Corrupted stream drops lock
		@(posedge clk);
		flip <= 1'b1;
		wt_lock(1'b0);
		wb(1'b0, `PCMF_A_STAT, 32'h0);
		chk("state_search", rd[3:0], 4'h0);
		chk("irq_loss", irq, 1'b1);
		wb(1'b0, `PCMF_A_ISTAT, 32'h0);
		chk("istat_loss", rd[2:0], 3'b110);
		// Relock with overhead stripped, counter status on sync detect
		flip <= 1'b0;
		wb(1'b1, `PCMF_A_CTRL, 32'hbd);
		wt_lock(1'b1);
		chk("sdet_early", sdet, 1'b0);
		n = 0;
		for (i = 0; i < 192; i++) begin
			do @(negedge clk); while (ren !== 1'b1);
			hist = {hist[23:0], rbit};
			@(negedge clk);
			if (rden === 1'b1) begin
				n++;
				if (i >= 24) chk("strip_data", rdat, hist[24]);
			end
		end
		chk("strip_count", n, 96);
		// Pattern payload, 33-bit sync, one clock per bit
		wb(1'b1, `PCMF_A_CTRL, 32'h0);
		wb(1'b1, `PCMF_A_SYNCLEN, 32'h21);
		wb(1'b1, `PCMF_A_PATLO, 32'hd2b471e3);
		wb(1'b1, `PCMF_A_PATHI, 32'h1);
		wb(1'b1, `PCMF_A_CORR, 32'h0202011e);
		wb(1'b1, `PCMF_A_GDIV, 32'h0);
		wb(1'b1, `PCMF_A_ICLR, 32'hf);
		slen_b = 33;
		ptn_b = 33'h1d2b471e3;
		gpat = 1'b1;
		gpos = 0;
		fidx = 0;
		pq.delete();
		wb(1'b1, `PCMF_A_CTRL, 32'h1f);
		wt_lock(1'b1);
		repeat (200) @(posedge clk);
		wb(1'b0, `PCMF_A_STAT, 32'h0);
		chk("prbs_state", rd[3:0], 4'he);
		wb(1'b0, `PCMF_A_ISTAT, 32'h0);
		chk("istat_major", rd[3:0], 4'h9);
		final_report;
	end
endmodule
